// ===== rtl/mcd_cfg.svh
// Purpose: constants of the mailbox command decoder
// Assumes: 32-bit AXI4-Lite register bus
// Notes: definitions only
`ifndef MCD_CFG_SVH
`define MCD_CFG_SVH

`define MCD_OFF_MBOX_OUT 12'h000
`define MCD_OFF_MBOX_IN 12'h004
`define MCD_OFF_STATUS 12'h008

`define MCD_RESP_OKAY 2'h0
`define MCD_RESP_SLVERR 2'h2

// top byte value that asks for a stored setting instead of running it
`define MCD_RB_MARK 8'h01

`define MCD_C_CLEAR 8'h00
`define MCD_C_RELAY_SET 8'h01
`define MCD_C_RELAY_RD 8'h02
`define MCD_C_STATUS_RD 8'h07
`define MCD_C_FW_RD 8'h0E
`define MCD_C_HW_RD 8'h0F
`define MCD_C_PWM_FIRST 8'h10
`define MCD_C_PWM_LAST 8'h15
`define MCD_C_PWM_EN 8'h1F
`define MCD_C_FILT_EN 8'h20
`define MCD_C_PAT_EN 8'h21
`define MCD_C_PAT_VAL 8'h22
`define MCD_C_RISE_EN 8'h23
`define MCD_C_FALL_EN 8'h24
`define MCD_C_CNT_EN 8'h28
`define MCD_C_CNT_RLD 8'h29
`define MCD_C_OVF_IE 8'h2A
`define MCD_C_MAT_IE 8'h2B
`define MCD_C_CNT_EDGE 8'h2C
`define MCD_C_CNT_RD 8'h2F
`define MCD_C_FILT_FIRST 8'h30
`define MCD_C_MATV_LAST 8'h4F
`define MCD_C_IRQ_RD 8'h60
`define MCD_C_EDGE_RD 8'h61
`define MCD_C_FLAG_RD 8'h62

// 0x40..0x47 reset values, 0x48..0x4F match values
`define MCD_GRP_RSTV 5'h08
`define MCD_GRP_MATV 5'h09

`define MCD_CNT_MAX 16'hFFFF
`define MCD_CNT_ONE 16'h0001

`endif

// ===== rtl/mcd_pkg.sv
// Purpose: shared types of the mailbox command decoder
// Assumes: nothing
// Notes: constants live in mcd_cfg.svh
package mcd_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_REPLY = 2'b10
	} mcd_state_e;

	typedef logic [7:0] mcd_byte_t;

endpackage : mcd_pkg

// ===== rtl/mcd_cfg_mem.sv
// Purpose: setting store for readback of configuration commands
// Assumes: one write port, one read port, same clock
// Notes: read data are registered, one cycle after the address
`timescale 1ns/1ps
module mcd_cfg_mem #(
	parameter int AW = 7,
	parameter int DW = 16
) (
	input wire logic aclk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata_q
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	// no reset: contents are only read after a write sets them
	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[raddr];
	end

endmodule : mcd_cfg_mem

// ===== rtl/mcd_top.sv
// Purpose: mailbox command interpreter for isolated inputs and relays
// Assumes: isolated_input synchronous to aclk
// Notes: one command at a time; reply two cycles after the write answer
// Function
// - a successful reply echoes the command code in reply byte two
// - every successful reply carries the eight input levels in the top byte
// - flag read: bit n of byte one is the overflow flag of channel n
// - flag read: bit n of byte zero is the match flag of channel n
// - in both flag bytes bit n belongs to input channel n
// - command 0x00 clears the echo byte to zero
// - 0x01 sets relay outputs, 0x02 reads relay status
// - 0x07 reads status, 0x0E firmware version, 0x0F hardware version
// - 0x10-0x13 pulse periods, 0x14-0x15 bursts, 0x1F pulse enable
// - 0x20 filter, 0x21 pattern, 0x22 pattern value, 0x23/0x24 edges
// - 0x28 count enable, 0x29 reload, 0x2A/0x2B irq enables, 0x2C, 0x2F
// - 0x30-0x37 high filter counts, 0x38-0x3F low filter counts
// - 0x40-0x47 counter reset values, 0x48-0x4F match values
// - 0x60 reads interrupt flags, 0x61 reads edge change flags
// - settings of readable configuration commands can be read back
// - interrupt flag reply bit 2 shows counter overflow or match interrupt
// - enabled match interrupt fires when a counter steps onto its match value
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "mcd_cfg.svh"
module mcd_top #(
	parameter logic [15:0] FW_VERSION = 16'h0001, // arbitrary value
	parameter logic [15:0] HW_VERSION = 16'h0001 // arbitrary value
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] isolated_input,
	output logic [7:0] relay_out,
	output logic [1:0] pulse_enable
);

	function automatic logic known_code(input logic [7:0] c);
		known_code = 1'b1;
		case (c)
			`MCD_C_CLEAR, `MCD_C_RELAY_SET, `MCD_C_RELAY_RD: ;
			`MCD_C_STATUS_RD, `MCD_C_FW_RD, `MCD_C_HW_RD: ;
			`MCD_C_CNT_RLD, `MCD_C_CNT_RD: ;
			`MCD_C_IRQ_RD, `MCD_C_EDGE_RD, `MCD_C_FLAG_RD: ;
			default: known_code = readable(c);
		endcase
	endfunction : known_code

	function automatic logic readable(input logic [7:0] c);
		readable = 1'b0;
		if (c >= `MCD_C_PWM_FIRST && c <= `MCD_C_PWM_LAST) begin
			readable = 1'b1;
		end
		case (c)
			`MCD_C_PWM_EN, `MCD_C_FILT_EN, `MCD_C_PAT_EN, `MCD_C_PAT_VAL,
			`MCD_C_RISE_EN, `MCD_C_FALL_EN: readable = 1'b1;
			`MCD_C_CNT_EN, `MCD_C_OVF_IE, `MCD_C_MAT_IE,
			`MCD_C_CNT_EDGE: readable = 1'b1;
			default: ;
		endcase
		if (c >= `MCD_C_FILT_FIRST && c <= `MCD_C_MATV_LAST) begin
			readable = 1'b1;
		end
	endfunction : readable

	mcd_pkg::mcd_state_e state_q, state_d;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, go_q;
	logic [1:0] bresp_q, rresp_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q, mbox_out_q, mbox_in_q;
	logic [3:0] wstrb_q;
	logic [7:0] relay_q, in_prev_q, pat_val_q, cnt_en_q, ovf_ie_q;
	logic [7:0] mat_ie_q, cnt_edge_q, ovf_q, mat_q, rise_flag_q, fall_flag_q;
	logic [1:0] pwm_en_q;
	logic pat_en_q;
	logic [7:0] rise_en_q, fall_en_q;
	logic [2:0] irq_q;
	logic [7:0][15:0] cnt_q, cnt_d, rstv_q, matv_q;
	logic [7:0] ovf_set, mat_set, cnt_load, cnt_step;
	logic [15:0] reply_lo, mem_rdata;
	mcd_pkg::mcd_byte_t reply_echo;

	// decode and selection
	wire busy = (state_q != mcd_pkg::ST_IDLE) || go_q;
	wire wr_fire = !awready_q && !wready_q && !bvalid_q;
	wire wr_mbox = awaddr_q == `MCD_OFF_MBOX_OUT;
	wire wr_ok = wr_mbox && !busy;
	wire [7:0] top = mbox_out_q[31:24];
	wire [7:0] code = mbox_out_q[23:16];
	wire [15:0] par = mbox_out_q[15:0];
	wire is_norm = top == 8'h00;
	wire is_rb = top == `MCD_RB_MARK;
	wire known = known_code(code);
	wire st_exec = state_q == mcd_pkg::ST_EXEC;
	wire st_reply = state_q == mcd_pkg::ST_REPLY;
	wire exec = st_exec && is_norm && known;
	wire mem_we = exec && readable(code);
	wire [4:0] grp = code[7:3];
	wire [7:0] rise = isolated_input & ~in_prev_q;
	wire [7:0] fall = ~isolated_input & in_prev_q;
	wire clr_flags = st_reply && is_norm && code == `MCD_C_FLAG_RD;
	wire clr_irq = st_reply && is_norm && code == `MCD_C_IRQ_RD;
	wire pat_hit = pat_en_q && isolated_input == pat_val_q && in_prev_q != pat_val_q;
	wire [2:0] irq_set = {|((ovf_set & ovf_ie_q) | (mat_set & mat_ie_q)),
		|((rise & rise_en_q) | (fall & fall_en_q)), pat_hit};
	wire [11:0] araddr = s_axi_araddr;
	wire rd_map = araddr == `MCD_OFF_MBOX_OUT || araddr == `MCD_OFF_MBOX_IN ||
		araddr == `MCD_OFF_STATUS;
	wire [31:0] rd_mux = araddr == `MCD_OFF_MBOX_OUT ? mbox_out_q :
		araddr == `MCD_OFF_MBOX_IN ? mbox_in_q :
		araddr == `MCD_OFF_STATUS ? {31'h0000_0000, busy} : 32'h0000_0000;
	wire [31:0] strb_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}},
		{8{wstrb_q[0]}}};

	mcd_cfg_mem #(
		.AW(7),
		.DW(16)
	) u_mem (
		.aclk(aclk),
		.we(mem_we),
		.waddr(code[6:0]),
		.wdata(par),
		.raddr(code[6:0]),
		.rdata_q(mem_rdata)
	);

	// write channel: address and data taken in any order, answer after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= `MCD_RESP_OKAY;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_q) begin
				awready_q <= 1'b0;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_q) begin
				wready_q <= 1'b0;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? `MCD_RESP_OKAY : `MCD_RESP_SLVERR;
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// read channel: data one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `MCD_RESP_OKAY;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_map ? `MCD_RESP_OKAY : `MCD_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	always_comb begin
		case (state_q)
			mcd_pkg::ST_IDLE: state_d = go_q ? mcd_pkg::ST_EXEC : mcd_pkg::ST_IDLE;
			mcd_pkg::ST_EXEC: state_d = mcd_pkg::ST_REPLY;
			mcd_pkg::ST_REPLY: state_d = mcd_pkg::ST_IDLE;
			default: state_d = mcd_pkg::ST_IDLE;
		endcase
	end

	// reply words; the readback data come from the store one cycle late
	always_comb begin
		reply_lo = 16'h0000;
		reply_echo = code;
		if (is_rb) begin
			if (readable(code)) begin
				reply_lo = mem_rdata;
			end else begin
				reply_echo = 8'h00;
			end
		end else if (!is_norm || !known) begin
			reply_echo = 8'h00;
		end else begin
			case (code)
				`MCD_C_RELAY_RD: reply_lo = {8'h00, relay_q};
				`MCD_C_STATUS_RD: reply_lo = {isolated_input, relay_q};
				`MCD_C_FW_RD: reply_lo = FW_VERSION;
				`MCD_C_HW_RD: reply_lo = HW_VERSION;
				`MCD_C_CNT_RD: reply_lo = cnt_q[par[2:0]];
				`MCD_C_IRQ_RD: reply_lo = {13'h0000, irq_q};
				`MCD_C_EDGE_RD: reply_lo = {fall_flag_q, rise_flag_q};
				`MCD_C_FLAG_RD: reply_lo = {ovf_q, mat_q};
				default: reply_lo = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= mcd_pkg::ST_IDLE;
			go_q <= 1'b0;
			mbox_out_q <= 32'h0000_0000;
			mbox_in_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			go_q <= wr_fire && wr_ok;
			if (wr_fire && wr_ok) begin
				mbox_out_q <= (mbox_out_q & ~strb_mask) | (wdata_q & strb_mask);
			end
			if (st_reply) begin
				mbox_in_q <= {isolated_input, reply_echo, reply_lo};
			end
		end
	end

	// settings that steer the block; all but the relay setting also go to the store
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			relay_q <= 8'h00;
			pwm_en_q <= 2'h0;
			pat_en_q <= 1'b0;
			pat_val_q <= 8'h00;
			rise_en_q <= 8'h00;
			fall_en_q <= 8'h00;
			cnt_en_q <= 8'h00;
			ovf_ie_q <= 8'h00;
			mat_ie_q <= 8'h00;
			cnt_edge_q <= 8'h00;
			rstv_q <= '0;
			matv_q <= '0;
		end else if (exec) begin
			case (code)
				`MCD_C_RELAY_SET: relay_q <= par[7:0];
				`MCD_C_PWM_EN: pwm_en_q <= par[1:0];
				`MCD_C_PAT_EN: pat_en_q <= par[0];
				`MCD_C_PAT_VAL: pat_val_q <= par[7:0];
				`MCD_C_RISE_EN: rise_en_q <= par[7:0];
				`MCD_C_FALL_EN: fall_en_q <= par[7:0];
				`MCD_C_CNT_EN: cnt_en_q <= par[7:0];
				`MCD_C_OVF_IE: ovf_ie_q <= par[7:0];
				`MCD_C_MAT_IE: mat_ie_q <= par[7:0];
				`MCD_C_CNT_EDGE: cnt_edge_q <= par[7:0];
				default: ;
			endcase
			if (grp == `MCD_GRP_RSTV) begin
				rstv_q[code[2:0]] <= par;
			end
			if (grp == `MCD_GRP_MATV) begin
				matv_q[code[2:0]] <= par;
			end
		end
	end

	// counters reload on the reload mask or when newly enabled
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			cnt_load[i] = exec && ((code == `MCD_C_CNT_RLD && par[i]) ||
				(code == `MCD_C_CNT_EN && par[i] && !cnt_en_q[i]));
			cnt_step[i] = cnt_en_q[i] && (cnt_edge_q[i] ? fall[i] : rise[i]);
			cnt_d[i] = cnt_q[i];
			ovf_set[i] = 1'b0;
			mat_set[i] = 1'b0;
			if (cnt_load[i]) begin
				cnt_d[i] = rstv_q[i];
			end else if (cnt_step[i]) begin
				cnt_d[i] = cnt_q[i] + `MCD_CNT_ONE;
				ovf_set[i] = cnt_q[i] == `MCD_CNT_MAX;
				mat_set[i] = cnt_d[i] == matv_q[i];
			end
		end
	end

	// sticky flags: a new event beats the clear of the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_prev_q <= 8'h00;
			cnt_q <= '0;
			ovf_q <= 8'h00;
			mat_q <= 8'h00;
			irq_q <= 3'h0;
			rise_flag_q <= 8'h00;
			fall_flag_q <= 8'h00;
		end else begin
			in_prev_q <= isolated_input;
			cnt_q <= cnt_d;
			ovf_q <= (ovf_q & ~{8{clr_flags}}) | ovf_set;
			mat_q <= (mat_q & ~{8{clr_flags}}) | mat_set;
			irq_q <= (irq_q & ~{3{clr_irq}}) | irq_set;
			rise_flag_q <= (rise_flag_q & ~fall) | rise;
			fall_flag_q <= (fall_flag_q & ~rise) | fall;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign relay_out = relay_q;
	assign pulse_enable = pwm_en_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_run;
		go_q ##1 st_exec ##1 st_reply;
	endsequence
	sequence s_reply_ok;
		st_reply && is_norm && known;
	endsequence

	a_cmd_run_steps: assert property (go_q |-> s_run)
		else $error("command did not run in two cycles");
	a_echo_code_ok: assert property (s_reply_ok |=> mbox_in_q[23:16] == $past(code))
		else $error("echo byte wrong");
	a_input_levels_top: assert property (st_reply |=>
		mbox_in_q[31:24] == $past(isolated_input))
		else $error("input levels missing from reply");
	a_ovf_byte_map: assert property ((s_reply_ok and (code == `MCD_C_FLAG_RD)) |=>
		mbox_in_q[15:8] == $past(ovf_q))
		else $error("overflow byte wrong");
	a_match_byte_map: assert property ((s_reply_ok and (code == `MCD_C_FLAG_RD)) |=>
		mbox_in_q[7:0] == $past(mat_q))
		else $error("match byte wrong");
	a_clear_echo_zero: assert property (st_reply && code == `MCD_C_CLEAR |=>
		mbox_in_q[23:16] == 8'h00)
		else $error("echo not cleared");
	a_readback_data: assert property (st_reply && is_rb && readable(code) |=>
		mbox_in_q[15:0] == $past(mem_rdata))
		else $error("readback wrong");
	a_cnt_irq_flag: assert property (|(ovf_set & ovf_ie_q) || |(mat_set & mat_ie_q)
		|=> irq_q[2] ##1 (irq_q[2] || $past(clr_irq)))
		else $error("counter interrupt flag not set");
	a_match_irq_set: assert property (|(mat_set & mat_ie_q) |=> irq_q[2])
		else $error("match interrupt lost");
	a_ovf_wrap_flag: assert property (|ovf_set |=>
		(ovf_q & $past(ovf_set)) == $past(ovf_set))
		else $error("wrap did not set overflow");
	a_unknown_noop: assert property (st_exec && !known |=>
		$stable(relay_q) && $stable(cnt_en_q) && $stable(pwm_en_q))
		else $error("unknown command changed a setting");

endmodule : mcd_top

// ===== verification/mcd_host.sv
// Purpose: host side model, an AXI4-Lite master for the mailbox registers
// Assumes: slave answers in its own time
// Notes: only the bench timeout ends a wait here; call wr right after a rising edge
`timescale 1ns/1ps
module mcd_host (
	input wire logic aclk,
	output logic [11:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [11:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		awaddr = 12'h000;
		awvalid = 1'b0;
		wdata = 32'h0000_0000;
		wvalid = 1'b0;
		// held high: a write response is always welcome
		bready = 1'b1;
		araddr = 12'h000;
		arvalid = 1'b0;
		rready = 1'b0;
	end

	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		// no extra edge first, so a write can follow a write back to back
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// each channel released on its own take, slave may take either first
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
endmodule : mcd_host

// ===== verification/mailbox_command_decoder_tb.sv
// Purpose: self-checking bench of the mailbox command decoder
// Assumes: host model drives the register bus
// Notes: table rows first, then readback, counters and bus refusals
`timescale 1ns/1ps
`include "mcd_cfg.svh"
module mailbox_command_decoder_tb;
	typedef struct {
		logic [31:0] w;
		logic [31:0] m;
		logic [31:0] e;
	} mcd_row_s;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] isolated_input = 8'h00;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, pulse_enable;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] relay_out;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	mcd_row_s rows [11] = '{
		'{32'h0001_0033, 32'hFFFF_0000, 32'hA501_0000},
		'{32'h0002_0000, 32'hFFFF_00FF, 32'hA502_0033},
		'{32'h0007_0000, 32'hFFFF_FFFF, 32'hA507_A533},
		'{32'h000E_0000, 32'hFFFF_FFFF, 32'hA50E_1234},
		'{32'h000F_0000, 32'hFFFF_FFFF, 32'hA50F_5678},
		'{32'h0062_0000, 32'hFFFF_FFFF, 32'hA562_0000},
		'{32'h0000_0000, 32'hFFFF_0000, 32'hA500_0000},
		'{32'h0003_0000, 32'hFFFF_FFFF, 32'hA500_0000},
		'{32'h0201_0077, 32'hFFFF_FFFF, 32'hA500_0000},
		'{32'h001F_0002, 32'hFFFF_0000, 32'hA51F_0000},
		'{32'h0129_0000, 32'hFFFF_0000, 32'hA500_0000}
	};
	// channel 2 counter: reload at 0xFFFE, match at 0xFFFF, then wrap
	logic [31:0] setup [9] = '{32'h0028_0000, 32'h0042_FFFE, 32'h004A_FFFF,
		32'h002C_0000, 32'h002A_0004, 32'h002B_0004, 32'h0062_0000,
		32'h0060_0000, 32'h0028_0004};

	always #2.5 aclk = ~aclk;

	// versions are arbitrary values
	mcd_top #(.FW_VERSION(16'h1234), .HW_VERSION(16'h5678)) DUT (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .isolated_input(isolated_input),
		.relay_out(relay_out), .pulse_enable(pulse_enable)
	);

	mcd_host HOST (
		.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic close_out();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	task automatic cmd(input logic [31:0] w, output logic [31:0] rep);
		logic [1:0] r;
		logic [31:0] s;
		HOST.wr(`MCD_OFF_MBOX_OUT, w, r);
		chk({30'h0, r}, {30'h0, `MCD_RESP_OKAY});
		// reply is ready two cycles after the write answer; three are waited, then busy is polled
		repeat (3) @(posedge aclk);
		s = 32'h0000_0001;
		while (s[0] !== 1'b0) begin
			HOST.rd(`MCD_OFF_STATUS, s, r);
		end
		HOST.rd(`MCD_OFF_MBOX_IN, rep, r);
	endtask : cmd

	task automatic run(input logic [31:0] w, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] rep;
		cmd(w, rep);
		chk(rep & m, e);
	endtask : run

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end

	initial begin
		logic [31:0] rep;
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] k;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		isolated_input <= 8'hA5;
		chk({24'h0, relay_out}, 32'h0000_0000);
		chk({30'h0, pulse_enable}, 32'h0000_0000);
		foreach (rows[i]) begin
			run(rows[i].w, rows[i].m, rows[i].e);
		end
		chk({24'h0, relay_out}, 32'h0000_0033);
		chk({30'h0, pulse_enable}, 32'h0000_0002);
		for (k = 8'h10; k < 8'h50; k++) begin
			if (k inside {[8'h10:8'h15], 8'h1F, [8'h20:8'h24], 8'h28, [8'h2A:8'h2C],
				[8'h30:8'h4F]}) begin
				run({8'h00, k, k, ~k}, 32'hFFFF_0000, {8'hA5, k, 16'h0000});
				run({8'h01, k, 16'h0000}, 32'hFFFF_FFFF, {8'hA5, k, k, ~k});
			end
		end
		run(32'h0055_AAAA, 32'hFFFF_FFFF, 32'hA500_0000);
		run(32'h0140_0000, 32'hFFFF_FFFF, 32'hA540_40BF);
		isolated_input <= 8'h00;
		foreach (setup[i]) begin
			cmd(setup[i], rep);
		end
		repeat (2) begin
			isolated_input <= 8'h04;
			repeat (4) @(posedge aclk);
			isolated_input <= 8'h00;
			repeat (4) @(posedge aclk);
		end
		run(32'h0062_0000, 32'hFFFF_FFFF, 32'h0062_0404);
		run(32'h0060_0000, 32'hFFFF_0004, 32'h0060_0004);
		run(32'h0062_0000, 32'hFFFF_FFFF, 32'h0062_0000);
		run(32'h002F_0002, 32'hFFFF_FFFF, 32'h002F_0000);
		run(32'h0061_0000, 32'hFFFF_0404, 32'h0061_0400);
		run(32'h0029_0004, 32'hFFFF_0000, 32'h0029_0000);
		run(32'h002F_0002, 32'hFFFF_FFFF, 32'h002F_FFFE);
		// second write lands while the first command still runs
		HOST.wr(`MCD_OFF_MBOX_OUT, 32'h0001_0099, r);
		HOST.wr(`MCD_OFF_MBOX_OUT, 32'h0001_00AA, r);
		chk({30'h0, r}, {30'h0, `MCD_RESP_SLVERR});
		repeat (4) @(posedge aclk);
		chk({24'h0, relay_out}, 32'h0000_0099);
		HOST.wr(`MCD_OFF_STATUS, 32'h0001_0011, r);
		chk({30'h0, r}, {30'h0, `MCD_RESP_SLVERR});
		HOST.rd(12'h00C, d, r);
		chk(d, 32'h0000_0000);
		chk({30'h0, r}, {30'h0, `MCD_RESP_SLVERR});
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		chk({24'h0, relay_out}, 32'h0000_0000);
		run(32'h0002_0000, 32'hFFFF_00FF, 32'h0002_0000);
		close_out();
	end
endmodule : mailbox_command_decoder_tb
